/* design/tag_ctrl_map.svh */
// offsets, field positions, reset values and timing counts of the general control register
`ifndef TAG_CTRL_MAP_SVH
`define TAG_CTRL_MAP_SVH
`define CTRL_ADDR_LO 16'hfffe
`define CTRL_ADDR_HI 16'hffff
`define CTRL_RESET 8'h00
`define BIT_SOFT_RESET 0
`define BIT_RADIO_EN 1
`define BIT_INT_EN 2
`define BIT_INT_HIGH 3
`define BIT_INT_DRIVE 4
`define BIT_PARITY_MODE 5
`define BIT_STANDBY_EN 6
`define BIT_SPARE 7
`define FLAG_MSG_FORMAT_ERR 5
`define CHECK_TIMEOUT_NS 100000
`define CLK_PERIOD_NS 50
`define CHECK_TIMEOUT_CYC ((`CHECK_TIMEOUT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* design/tag_ctrl_pkg.sv */
// types of the general control register block
package tag_ctrl_pkg;
    typedef struct packed {
        logic stb;
        logic write;
        logic word;
        logic [15:0] addr;
        logic [15:0] data;
        logic [7:0] dummy;
        logic [7:0] parity;
    } ser_req_t;
    typedef struct packed {
        logic valid;
        logic [15:0] data;
        logic [7:0] parity;
    } ser_rsp_t;
    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_CHECK = 1'b1
    } check_state_t;
endpackage

/* design/tag_general_control.sv */
// general control register of the tag with interrupt pin shaping and structure check start
//
// Notes on behaviour
// [RL1] writing one to soft reset resets everything, erases memory; bit reads zero
// [RL2] host waits restart delay after soft reset, then restores registers and memory
// [RL3] bit 1 is radio enable, read/write, resets zero, zero means disabled
// [RL4] setting radio enable runs a structure check; failure keeps radio off, raises flag
// [RL5] host should clear radio enable before writing message memory
// [RL6] host avoids serial writes other than radio disable while radio enabled
// [RL7] interrupt output enable zero leaves the interrupt pin high impedance
// [RL8] interrupt output enable one shows pending enabled interrupts with chosen style
// [RL9] bit 3 picks polarity: zero asserts low, one asserts high
// [RL10] bit 4 zero releases pin to high impedance when nothing pends
// [RL11] bit 4 one drives idle level: high for active low, low for active high
// [RL12] bit 5 enables parity framing mode, read/write, resets zero
// [RL13] parity byte is bytewise xor of covered bytes, giving even parity per bit
// [RL14] host formats every transaction per parity framing once the mode is set
// [RL15] standby only when enabled, radio off, watchdog off, no serial transfer
// [RL16] control bits at even address, reserved high byte at odd address
// [RL17] all enabled interrupt sources are ored into one pin request
// [RL18] framed write with wrong parity byte is discarded without change
// [RL19] message format error is flag bit 5, set when the check fails
// [RL20] bits 8 to 15 read zero, ignore writes; bit 7 stores freely
// [RL21] radio enable reads one after a passing check, zero after failing
`timescale 1ns/10ps
`default_nettype none
`include "tag_ctrl_map.svh"
module tag_general_control
    import tag_ctrl_pkg::*;
#(
    parameter int CHECK_TIMEOUT = `CHECK_TIMEOUT_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire ser_req_t ser_req,
    output ser_rsp_t ser_rsp,
    input wire logic [7:0] irq_enabled_pending,
    input wire logic check_done,
    input wire logic check_ok,
    input wire logic watchdog_en,
    input wire logic serial_busy,
    output logic check_start,
    output logic [7:0] irq_flag_set,
    output logic parity_error,
    output logic device_reset,
    output logic radio_enable,
    output logic parity_mode,
    output logic standby,
    output logic int_out,
    output logic int_oe
);

    // ----------------------------------------------------------------
    // request decode
    // ----------------------------------------------------------------
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    check_state_t state_reg;
    logic [15:0] timeout_reg;
    logic [7:0] wr_parity;
    logic [7:0] rd_parity;
    logic [15:0] rd_word;
    logic hit_lo;
    logic hit_hi;
    logic wr_ok;
    logic wr_lo;
    logic [7:0] wr_byte;
    logic soft_rst;
    logic radio_req;
    logic pending;

    assign wr_parity = ser_req.addr[15:8] ^ ser_req.addr[7:0]
                       ^ ser_req.data[7:0] ^ ser_req.data[15:8]; // RL13
    assign hit_lo = ser_req.addr == `CTRL_ADDR_LO; // RL16
    assign hit_hi = ser_req.addr == `CTRL_ADDR_HI; // RL16
    // framed writes only land when the parity byte agrees
    assign wr_ok = ser_req.stb && ser_req.write
                   && (!ctrl_reg[`BIT_PARITY_MODE] || wr_parity == ser_req.parity); // RL18
    // word access at the even address carries the control byte first
    assign wr_lo = wr_ok && hit_lo; // RL16
    assign wr_byte = ser_req.data[7:0];
    assign soft_rst = wr_lo && wr_byte[`BIT_SOFT_RESET]; // RL1
    assign radio_req = wr_lo && wr_byte[`BIT_RADIO_EN] && !ctrl_reg[`BIT_RADIO_EN]
                       && state_reg == ST_IDLE; // RL4

    // ----------------------------------------------------------------
    // control register
    // ----------------------------------------------------------------
    always_comb begin
        ctrl_next = ctrl_reg;
        if (soft_rst) begin
            ctrl_next = `CTRL_RESET; // RL1
        end else if (wr_lo) begin
            ctrl_next = wr_byte; // RL20
            ctrl_next[`BIT_SOFT_RESET] = 1'b0; // RL1
            // radio enable only rises through a passing check
            ctrl_next[`BIT_RADIO_EN] = wr_byte[`BIT_RADIO_EN] && ctrl_reg[`BIT_RADIO_EN]; // RL4
        end
        if (!soft_rst && state_reg == ST_CHECK && check_done && check_ok) begin
            ctrl_next[`BIT_RADIO_EN] = 1'b1; // RL21
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= `CTRL_RESET; // RL3
        end else begin
            ctrl_reg <= ctrl_next; // RL12
        end
    end

    // ----------------------------------------------------------------
    // structure check sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            timeout_reg <= 16'h0000;
            check_start <= 1'b0;
            irq_flag_set <= 8'h00;
        end else begin
            check_start <= 1'b0;
            irq_flag_set <= 8'h00;
            unique case (state_reg)
                ST_IDLE: begin
                    if (radio_req && !soft_rst) begin
                        state_reg <= ST_CHECK; // RL4
                        check_start <= 1'b1;
                        timeout_reg <= 16'h0000;
                    end
                end
                ST_CHECK: begin
                    timeout_reg <= timeout_reg + 16'h0001;
                    if (soft_rst) begin
                        state_reg <= ST_IDLE;
                    end else if (check_done && check_ok) begin
                        state_reg <= ST_IDLE; // RL21
                    end else if (check_done || timeout_reg == 16'(CHECK_TIMEOUT - 1)) begin
                        state_reg <= ST_IDLE;
                        irq_flag_set[`FLAG_MSG_FORMAT_ERR] <= 1'b1; // RL19
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // read path and parity error
    // ----------------------------------------------------------------
    always_comb begin
        rd_word = 16'h0000;
        if (hit_lo) begin
            rd_word = {8'h00, ctrl_reg}; // RL20
        end else if (hit_hi) begin
            rd_word = 16'h0000; // RL20
        end
    end
    assign rd_parity = ser_req.addr[15:8] ^ ser_req.addr[7:0] ^ ser_req.dummy
                       ^ rd_word[7:0] ^ rd_word[15:8]; // RL13

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ser_rsp <= '0;
            parity_error <= 1'b0;
            device_reset <= 1'b0;
        end else begin
            ser_rsp.valid <= ser_req.stb && !ser_req.write;
            ser_rsp.data <= rd_word;
            ser_rsp.parity <= rd_parity;
            parity_error <= ser_req.stb && ser_req.write && ctrl_reg[`BIT_PARITY_MODE]
                            && wr_parity != ser_req.parity; // RL18
            device_reset <= soft_rst; // RL1
        end
    end

    // ----------------------------------------------------------------
    // interrupt pin and mode outputs
    // ----------------------------------------------------------------
    assign pending = |irq_enabled_pending; // RL17

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            int_out <= 1'b0;
            int_oe <= 1'b0;
            radio_enable <= 1'b0;
            parity_mode <= 1'b0;
            standby <= 1'b0;
        end else begin
            // asserted level follows polarity, idle level is its opposite
            int_out <= pending ? ctrl_next[`BIT_INT_HIGH] : !ctrl_next[`BIT_INT_HIGH]; // RL9
            int_oe <= ctrl_next[`BIT_INT_EN]
                      && (pending || ctrl_next[`BIT_INT_DRIVE]); // RL7 RL8 RL10 RL11
            radio_enable <= ctrl_next[`BIT_RADIO_EN]; // RL3
            parity_mode <= ctrl_next[`BIT_PARITY_MODE]; // RL12
            standby <= ctrl_next[`BIT_STANDBY_EN] && !ctrl_next[`BIT_RADIO_EN]
                       && !watchdog_en && !serial_busy && state_reg == ST_IDLE; // RL15
        end
    end

    // ----------------------------------------------------------------
    // control register checks
    // ----------------------------------------------------------------
    a_soft_reset_clears: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL1
        soft_rst |=> ctrl_reg == `CTRL_RESET && device_reset && state_reg == ST_IDLE)
        else $error("soft reset did not clear the control register");
    a_reset_bit_zero: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL1
        ctrl_reg[`BIT_SOFT_RESET] == 1'b0)
        else $error("soft reset bit read back as one");
    a_radio_clear: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL3
        wr_lo && !wr_byte[`BIT_RADIO_EN] && state_reg == ST_IDLE
        |=> !ctrl_reg[`BIT_RADIO_EN] && !radio_enable)
        else $error("radio enable not cleared by a write of zero");
    a_spare_stores: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL20
        wr_lo && !soft_rst |=> ctrl_reg[`BIT_SPARE] == $past(wr_byte[`BIT_SPARE]))
        else $error("spare bit did not keep the written value");
    a_high_ignored: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL20
        ser_req.stb && ser_req.write && hit_hi && state_reg == ST_IDLE |=> $stable(ctrl_reg))
        else $error("write to the reserved byte changed the register");
    a_mode_follows: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL12
        wr_lo && !soft_rst |=> parity_mode == $past(wr_byte[`BIT_PARITY_MODE])
        && ctrl_reg[`BIT_PARITY_MODE] == parity_mode)
        else $error("parity mode does not follow the written bit");

    // ----------------------------------------------------------------
    // structure check checks
    // ----------------------------------------------------------------
    a_check_starts: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL4
        radio_req && !soft_rst |=> check_start && state_reg == ST_CHECK && !radio_enable)
        else $error("radio enable request did not start a check");
    a_check_one_shot: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL4
        check_start |=> !check_start)
        else $error("check start longer than one cycle");
    a_radio_waits_check: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL4
        $rose(ctrl_reg[`BIT_RADIO_EN]) |-> $past(state_reg) == ST_CHECK
        && $past(check_done) && $past(check_ok))
        else $error("radio enabled without a passing check");
    a_fail_flags_error: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL19
        state_reg == ST_CHECK && check_done && !check_ok && !soft_rst
        |=> irq_flag_set[`FLAG_MSG_FORMAT_ERR] && !ctrl_reg[`BIT_RADIO_EN])
        else $error("failed check did not raise message format error");
    a_timeout_flags: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL19
        state_reg == ST_CHECK && !check_done && !soft_rst
        && timeout_reg == 16'(CHECK_TIMEOUT - 1)
        |=> irq_flag_set[`FLAG_MSG_FORMAT_ERR] && state_reg == ST_IDLE
        && !ctrl_reg[`BIT_RADIO_EN])
        else $error("check without answer did not raise message format error");
    a_flag_needs_check: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL19
        irq_flag_set[`FLAG_MSG_FORMAT_ERR] |-> $past(state_reg) == ST_CHECK
        && !$past(soft_rst))
        else $error("message format error raised outside a check");
    a_pass_reads_one: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL21
        state_reg == ST_CHECK && check_done && check_ok && !soft_rst
        |=> ctrl_reg[`BIT_RADIO_EN] && radio_enable)
        else $error("passing check did not set radio enable");

    // ----------------------------------------------------------------
    // read path and parity error checks
    // ----------------------------------------------------------------
    a_read_ctrl_byte: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL16
        ser_req.stb && !ser_req.write && hit_lo
        |=> ser_rsp.valid && ser_rsp.data == {8'h00, $past(ctrl_reg)})
        else $error("control byte not returned at the even address");
    a_read_high_zero: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL20
        ser_req.stb && !ser_req.write && hit_hi
        |=> ser_rsp.valid && ser_rsp.data == 16'h0000)
        else $error("reserved byte did not read as zero");
    a_read_parity: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL13
        ser_req.stb && !ser_req.write
        |=> ser_rsp.parity == ($past(ser_req.addr[15:8]) ^ $past(ser_req.addr[7:0])
        ^ $past(ser_req.dummy) ^ ser_rsp.data[7:0] ^ ser_rsp.data[15:8]))
        else $error("read parity byte wrong");
    a_good_write_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL18
        wr_ok |=> !parity_error)
        else $error("parity error flagged for an accepted write");
    a_bad_parity_drop: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL18
        ser_req.stb && ser_req.write && ctrl_reg[`BIT_PARITY_MODE]
        && wr_parity != ser_req.parity && state_reg == ST_IDLE
        && !(check_done && check_ok) |=> $stable(ctrl_reg) && parity_error)
        else $error("write with bad parity changed the register");

    // ----------------------------------------------------------------
    // interrupt pin checks
    // ----------------------------------------------------------------
    a_pin_released: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL7
        !ctrl_reg[`BIT_INT_EN] |-> !int_oe)
        else $error("interrupt pin driven while output disabled");
    a_pin_asserted: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL8 RL9
        ctrl_next[`BIT_INT_EN] && pending
        |=> int_oe && int_out == $past(ctrl_next[`BIT_INT_HIGH]))
        else $error("pending interrupt not shown with chosen polarity");
    a_pin_idle_drive: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL10 RL11
        ctrl_next[`BIT_INT_EN] && !pending
        |=> int_oe == $past(ctrl_next[`BIT_INT_DRIVE])
        && int_out == !$past(ctrl_next[`BIT_INT_HIGH]))
        else $error("idle interrupt pin level or drive wrong");
    a_irq_or: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL17
        ctrl_next[`BIT_INT_EN] && |irq_enabled_pending |=> int_oe)
        else $error("single enabled pending source did not drive the pin");

    // ----------------------------------------------------------------
    // standby checks
    // ----------------------------------------------------------------
    a_standby_gate: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL15
        standby |-> !radio_enable && !$past(watchdog_en) && !$past(serial_busy))
        else $error("standby entered while not allowed");
    a_standby_entry: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL15
        ctrl_next[`BIT_STANDBY_EN] && !ctrl_next[`BIT_RADIO_EN] && !watchdog_en
        && !serial_busy && state_reg == ST_IDLE |=> standby)
        else $error("standby not entered while allowed");

endmodule
`default_nettype wire

/* bench/tag_host_model.sv */
// host side model: serial requests and structure check responder
`timescale 1ns/10ps
`default_nettype none
module tag_host_model
    import tag_ctrl_pkg::*;
(
    input wire logic ref_clk,
    output ser_req_t ser_req,
    input wire ser_rsp_t ser_rsp,
    input wire logic check_start,
    input wire logic answer_ok,
    input wire logic answer_mute,
    output logic check_done,
    output logic check_ok
);
    logic [1:0] cnt;
    initial begin
        ser_req = '0;
        check_done = 1'b0;
        check_ok = 1'b0;
        cnt = 2'd0;
    end
    // check answers four cycles after start unless muted; ok toggles outside the done cycle
    always @(posedge ref_clk) begin
        check_done <= (cnt == 2'd1);
        check_ok <= (cnt == 2'd1) ? answer_ok : ~check_ok;
        cnt <= (check_start && !answer_mute) ? 2'd3 : (cnt != 2'd0) ? cnt - 2'd1 : 2'd0;
    end
    // one request held over its taking edge, answer taken one edge later
    task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] d,
        input logic bad, output logic [15:0] rd, output logic [7:0] rp, output logic v);
        @(posedge ref_clk);
        ser_req <= '{1'b1, wr, 1'b1, a, d, wr ? 8'h00 : 8'h5a,
            a[15:8] ^ a[7:0] ^ d[7:0] ^ d[15:8] ^ {7'h00, bad}};
        @(posedge ref_clk);
        ser_req <= '{1'b0, ~wr, 1'b0, ~a, ~d, 8'ha5, 8'h3c};
        @(posedge ref_clk);
        rd = ser_rsp.data;
        rp = ser_rsp.parity;
        v = ser_rsp.valid;
    endtask
endmodule
`default_nettype wire

/* bench/tag_general_control_tb.sv */
// self-checking testbench of the general control register
`timescale 1ns/10ps
`default_nettype none
module tag_general_control_tb
    import tag_ctrl_pkg::*;
;
    logic ref_clk, rst_n, check_done, check_ok, watchdog_en, serial_busy, answer_ok, answer_mute;
    logic check_start, parity_error, device_reset, radio_enable, parity_mode, standby;
    logic int_out, int_oe, v;
    logic [7:0] irq_enabled_pending, irq_flag_set, rp;
    logic [15:0] rd;
    ser_req_t ser_req;
    ser_rsp_t ser_rsp;
    int err_count = 0, num_checks = 0, n_flag = 0, n_perr = 0, n_rst = 0, k;
    tag_general_control #(.CHECK_TIMEOUT(64)) u_tag_general_control(.ref_clk(ref_clk),
        .rst_n(rst_n), .ser_req(ser_req), .ser_rsp(ser_rsp),
        .irq_enabled_pending(irq_enabled_pending), .check_done(check_done),
        .check_ok(check_ok), .watchdog_en(watchdog_en), .serial_busy(serial_busy),
        .check_start(check_start), .irq_flag_set(irq_flag_set), .parity_error(parity_error),
        .device_reset(device_reset), .radio_enable(radio_enable), .parity_mode(parity_mode),
        .standby(standby), .int_out(int_out), .int_oe(int_oe));
    tag_host_model u_tag_host_model(.ref_clk(ref_clk), .ser_req(ser_req),
        .ser_rsp(ser_rsp), .check_start(check_start), .answer_ok(answer_ok),
        .answer_mute(answer_mute), .check_done(check_done), .check_ok(check_ok));
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        n_flag += irq_flag_set[5];
        n_perr += parity_error;
        n_rst += device_reset;
    end
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic bad);
        u_tag_host_model.access(1'b1, a, d, bad, rd, rp, v);
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic rdx(input logic [15:0] a, input logic [15:0] e);
        u_tag_host_model.access(1'b0, a, 16'h0000, 1'b0, rd, rp, v);
        chk("valid", 16'h0001, {15'h0000, v});
        chk("read", e, rd);
        chk("parity", {8'h00, a[15:8] ^ a[7:0] ^ 8'h5a ^ e[7:0] ^ e[15:8]}, {8'h00, rp});
    endtask
    task automatic t_regs();
        rdx(16'hfffe, 16'h0000);
        rdx(16'hffff, 16'h0000);
        wr(16'hffff, 16'hffff, 1'b0);
        wr(16'hfffe, 16'hff80, 1'b0);
        rdx(16'hfffe, 16'h0080);
        wr(16'hfffe, 16'h0000, 1'b0);
        $display("test regs done");
    endtask
    task automatic t_radio();
        answer_ok <= 1'b1;
        wr(16'hfffe, 16'h0002, 1'b0);
        for (k = 0; k < 20 && radio_enable !== 1'b1; k++) @(posedge ref_clk);
        chk("radio", 16'h0001, {15'h0000, radio_enable});
        rdx(16'hfffe, 16'h0002);
        wr(16'hfffe, 16'h0000, 1'b0);
        chk("radio off", 16'h0000, {15'h0000, radio_enable});
        answer_ok <= 1'b0;
        k = n_flag;
        wr(16'hfffe, 16'h0002, 1'b0);
        repeat (10) @(posedge ref_clk);
        chk("format flag", 16'h0001, 16'(n_flag - k));
        rdx(16'hfffe, 16'h0000);
        answer_mute <= 1'b1;
        k = n_flag;
        wr(16'hfffe, 16'h0002, 1'b0);
        repeat (70) @(posedge ref_clk);
        chk("timeout flag", 16'h0001, 16'(n_flag - k));
        chk("radio held", 16'h0000, {15'h0000, radio_enable});
        answer_mute <= 1'b0;
        rdx(16'hfffe, 16'h0000);
        $display("test radio done");
    endtask
    task automatic t_irq();
        for (int c = 0; c < 16; c++) begin
            wr(16'hfffe, {11'h000, c[2:0], 2'b00}, 1'b0);
            irq_enabled_pending <= c[3] ? 8'h01 << c[2:0] : 8'h00;
            repeat (2) @(posedge ref_clk);
            chk("oe", {15'h0000, c[0] & (c[3] | c[2])}, {15'h0000, int_oe});
            if (c[0] & (c[3] | c[2]))
                chk("out", {15'h0000, c[3] ~^ c[1]}, {15'h0000, int_out});
        end
        irq_enabled_pending <= 8'h00;
        $display("test irq done");
    endtask
    task automatic t_parity();
        wr(16'hfffe, 16'h0020, 1'b0);
        rdx(16'hfffe, 16'h0020);
        k = n_perr;
        wr(16'hfffe, 16'h0028, 1'b1);
        chk("parity error", 16'h0001, 16'(n_perr - k));
        rdx(16'hfffe, 16'h0020);
        wr(16'hfffe, 16'h0028, 1'b0);
        rdx(16'hfffe, 16'h0028);
        wr(16'hfffe, 16'h0000, 1'b0);
        $display("test parity done");
    endtask
    task automatic t_standby();
        wr(16'hfffe, 16'h0040, 1'b0);
        chk("standby", 16'h0001, {15'h0000, standby});
        serial_busy <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk("busy", 16'h0000, {15'h0000, standby});
        serial_busy <= 1'b0;
        watchdog_en <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk("watchdog", 16'h0000, {15'h0000, standby});
        watchdog_en <= 1'b0;
        k = n_rst;
        wr(16'hfffe, 16'h005d, 1'b0);
        chk("soft reset", 16'h0001, 16'(n_rst - k));
        repeat (8) @(posedge ref_clk);
        rdx(16'hfffe, 16'h0000);
        $display("test standby done");
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        summarize();
    end
    initial begin
        {rst_n, watchdog_en, serial_busy, answer_ok, answer_mute, irq_enabled_pending} = '0;
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_regs();
        t_radio();
        t_irq();
        t_parity();
        t_standby();
        summarize();
    end
endmodule
`default_nettype wire
